// [rtl/mgr_config_bank.sv]
// general and input-range configuration registers with their static control outputs
// Functional notes
// - with both shutdown pins in shutdown function, bits 2:1 pick the disable mode
// - mode 00 both resistors, 01 large only, 10 small only, 11 high impedance
// - bit 5 sets second limit-flag polarity; 0 active low, 1 active high
// - bit 4 sets first limit-flag polarity; 0 active low, 1 active high
// - bit 8 selects reference; 0 internal, 1 external
// - which dacs each shutdown pin acts on comes from the per-pin select registers
// - each range register holds one bit per channel in bits 7:0
// - same channel bit set in both range registers gives divide-by-4
// - channels sampled against the positive supply ignore both range bits
// - both range registers reset to zero, no divide factor after reset
// - sampling bits 15:8 choose reference point; 0 positive supply, 1 ground
// - pin function bit 0 selects alternate function, 1 general-purpose use
// - every register of the bank holds all zeros after reset
`timescale 1ns/1ps

module mgr_config_bank
    import mgr_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire mgr_bus_req_t bus_req,
    output logic [15:0]       rd_data,
    input  wire logic         alert_a_raw,
    input  wire logic         alert_b_raw,
    input  wire logic         dac_shutdown_in_a,
    input  wire logic         dac_shutdown_in_b,
    output logic              ref_external,
    output logic              limit_flag_out_a,
    output logic              limit_flag_oe_a,
    output logic              limit_flag_out_b,
    output logic              limit_flag_oe_b,
    output mgr_dac_ctl_t      dac_ctl,
    output mgr_range_t        range_cfg
);

    logic [15:0] pin_func;
    logic [15:0] general_config;
    logic [15:0] input_range_a;
    logic [15:0] input_range_b;
    logic [15:0] sampling_mode;
    logic [15:0] shdn_sel_a;
    logic [15:0] shdn_sel_b;

    // read mux for the register port; unmapped addresses read as zero
    function automatic logic [15:0] reg_read(input logic [7:0] a);
        logic [15:0] v;
        v = REG_RESET;
        case (a)
            ADDR_PIN_FUNC: v = pin_func;
            ADDR_GENERAL:  v = general_config;
            ADDR_RANGE_A:  v = input_range_a;
            ADDR_RANGE_B:  v = input_range_b;
            ADDR_SAMPLING: v = sampling_mode;
            ADDR_SHDN_A:   v = shdn_sel_a;
            ADDR_SHDN_B:   v = shdn_sel_b;
            default:       v = REG_RESET;
        endcase
        return v;
    endfunction

    // divide code for one channel: count of range bits, void when sampled against supply
    function automatic logic [1:0] range_code(input logic a, input logic b,
                                              input logic agnd);
        logic [1:0] c;
        c = {1'b0, a} + {1'b0, b};
        return agnd ? c : 2'h0;
    endfunction

    function automatic logic is_wr(input mgr_bus_req_t r, input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction

    // register storage: whole words kept so reserved bits read back as written
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_func       <= REG_RESET;
            general_config <= REG_RESET;
            input_range_a  <= REG_RESET;
            input_range_b  <= REG_RESET;
            sampling_mode  <= REG_RESET;
            shdn_sel_a     <= REG_RESET;
            shdn_sel_b     <= REG_RESET;
        end else begin
            if (is_wr(bus_req, ADDR_PIN_FUNC)) begin
                pin_func <= bus_req.wdata;
            end
            if (is_wr(bus_req, ADDR_GENERAL)) begin
                general_config <= bus_req.wdata;
            end
            if (is_wr(bus_req, ADDR_RANGE_A)) begin
                input_range_a <= bus_req.wdata;
            end
            if (is_wr(bus_req, ADDR_RANGE_B)) begin
                input_range_b <= bus_req.wdata;
            end
            if (is_wr(bus_req, ADDR_SAMPLING)) begin
                sampling_mode <= bus_req.wdata;
            end
            if (is_wr(bus_req, ADDR_SHDN_A)) begin
                shdn_sel_a <= bus_req.wdata;
            end
            if (is_wr(bus_req, ADDR_SHDN_B)) begin
                shdn_sel_b <= bus_req.wdata;
            end
        end
    end

    // read data stands only in the cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data <= REG_RESET;
        end else if (bus_req.rd) begin
            rd_data <= reg_read(bus_req.addr);
        end else begin
            rd_data <= REG_RESET;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ref_external <= 1'b0;
        end else begin
            ref_external <= general_config[GEN_REF_BIT];
        end
    end

    // limit flags: polarity bit 0 drives the pin low while the condition holds
    logic alt_zero;
    logic alt_one;
    assign alt_zero = ~pin_func[PIN_ZERO_BIT];
    assign alt_one  = ~pin_func[PIN_ONE_BIT];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            limit_flag_out_a <= 1'b0;
            limit_flag_oe_a  <= 1'b0;
            limit_flag_out_b <= 1'b0;
            limit_flag_oe_b  <= 1'b0;
        end else begin
            limit_flag_oe_a  <= alt_zero;
            limit_flag_oe_b  <= alt_one;
            limit_flag_out_a <= alt_zero &
                                ~(alert_a_raw ^ general_config[GEN_POL_A_BIT]);
            limit_flag_out_b <= alt_one &
                                ~(alert_b_raw ^ general_config[GEN_POL_B_BIT]);
        end
    end

    // dac shutdown: mode applies only when both pins serve as shutdown inputs
    logic      alt_two;
    logic      alt_four;
    logic      both_shdn;
    mgr_term_t term_mode;
    assign alt_two   = ~pin_func[PIN_TWO_BIT];
    assign alt_four  = ~pin_func[PIN_FOUR_BIT];
    assign both_shdn = alt_two & alt_four;
    assign term_mode = mgr_term_t'(general_config[GEN_MODE_HI:GEN_MODE_LO]);

    logic [NUM_DAC-1:0] next_off;
    assign next_off = ({NUM_DAC{alt_two & dac_shutdown_in_a}} & shdn_sel_a[NUM_DAC-1:0]) |
                      ({NUM_DAC{alt_four & dac_shutdown_in_b}} & shdn_sel_b[NUM_DAC-1:0]);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dac_ctl <= '0;
        end else begin
            dac_ctl.off  <= next_off;
            dac_ctl.mode <= both_shdn ? term_mode : MGR_TERM_BOTH;
            // a non-shutdown pin setup keeps the default termination, never floats
            case (both_shdn ? term_mode : MGR_TERM_BOTH)
                MGR_TERM_BOTH: begin
                    dac_ctl.large_res_en <= 1'b1;
                    dac_ctl.small_res_en <= 1'b1;
                end
                MGR_TERM_LARGE: begin
                    dac_ctl.large_res_en <= 1'b1;
                    dac_ctl.small_res_en <= 1'b0;
                end
                MGR_TERM_SMALL: begin
                    dac_ctl.large_res_en <= 1'b0;
                    dac_ctl.small_res_en <= 1'b1;
                end
                default: begin
                    dac_ctl.large_res_en <= 1'b0;
                    dac_ctl.small_res_en <= 1'b0;
                end
            endcase
        end
    end

    // input range per channel
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            range_cfg <= '0;
        end else begin
            for (int n = 0; n < NUM_CH; n++) begin
                range_cfg.ref_agnd[n] <= sampling_mode[SAMP_LO + n];
                range_cfg.div_code[n] <= range_code(input_range_a[n], input_range_b[n],
                                                    sampling_mode[SAMP_LO + n]);
            end
        end
    end

    // checks, all on the bank clock and quiet while reset is held
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ref_select_a: assert property (
        is_wr(bus_req, ADDR_GENERAL) |-> ##2 ref_external == $past(bus_req.wdata[GEN_REF_BIT], 2)
    ) else $error("reference select does not follow general bit 8");

    ref_hold_a: assert property (
        !is_wr(bus_req, ADDR_GENERAL) |-> ##2 $stable(ref_external)
    ) else $error("reference select moved without a general write");

    mode_decode_a: assert property (
        both_shdn && term_mode == MGR_TERM_SMALL |=> !dac_ctl.large_res_en && dac_ctl.small_res_en
    ) else $error("small-resistor mode decoded wrongly");

    mode_large_a: assert property (
        both_shdn && term_mode == MGR_TERM_LARGE |=> dac_ctl.large_res_en && !dac_ctl.small_res_en
    ) else $error("large-resistor mode decoded wrongly");

    mode_hiz_a: assert property (
        both_shdn && term_mode == MGR_TERM_HIZ |=> !dac_ctl.large_res_en && !dac_ctl.small_res_en
    ) else $error("high-impedance mode still connects a resistor");

    mode_gate_a: assert property (
        !both_shdn |=> dac_ctl.mode == MGR_TERM_BOTH && dac_ctl.large_res_en
    ) else $error("disable mode applied without both shutdown pins");

    mode_follow_a: assert property (
        both_shdn |=> dac_ctl.mode == $past(term_mode)
    ) else $error("disable mode does not follow general bits 2:1");

    polarity_a_a: assert property (
        alt_zero && general_config[GEN_POL_A_BIT] == 1'b0 && alert_a_raw |=> !limit_flag_out_a
    ) else $error("first limit flag not active low");

    flag_a_high_a: assert property (
        alt_zero && general_config[GEN_POL_A_BIT] |=> limit_flag_out_a == $past(alert_a_raw)
    ) else $error("first limit flag not active high");

    flag_a_quiet_a: assert property (
        pin_func[PIN_ZERO_BIT] |=> !limit_flag_out_a
    ) else $error("first limit flag driven while pin is general-purpose");

    polarity_b_a: assert property (
        alt_one && general_config[GEN_POL_B_BIT] && alert_b_raw |=> limit_flag_out_b
    ) else $error("second limit flag not active high");

    flag_b_low_a: assert property (
        alt_one && !general_config[GEN_POL_B_BIT] |=> limit_flag_out_b == !$past(alert_b_raw)
    ) else $error("second limit flag not active low");

    flag_b_quiet_a: assert property (
        pin_func[PIN_ONE_BIT] |=> !limit_flag_oe_b && !limit_flag_out_b
    ) else $error("second limit flag driven while pin is general-purpose");

    flag_b_drive_a: assert property (
        !pin_func[PIN_ONE_BIT] |=> limit_flag_oe_b
    ) else $error("second limit flag not driven in alert use");

    shdn_select_a: assert property (
        alt_two && dac_shutdown_in_a && shdn_sel_a[0] |=> dac_ctl.off[0]
    ) else $error("shutdown pin a ignores its select register");

    shdn_b_select_a: assert property (
        alt_four && dac_shutdown_in_b && shdn_sel_b[3] |=> dac_ctl.off[3]
    ) else $error("shutdown pin b ignores its select register");

    shdn_idle_a: assert property (
        !dac_shutdown_in_a && !dac_shutdown_in_b |=> dac_ctl.off == 4'h0
    ) else $error("dac held off with both shutdown pins idle");

    shdn_released_a: assert property (
        pin_func[PIN_TWO_BIT] && pin_func[PIN_FOUR_BIT] |=> dac_ctl.off == 4'h0
    ) else $error("dac held off by pins in general-purpose use");

    range_div2_a: assert property (
        input_range_a[0] && !input_range_b[0] && sampling_mode[SAMP_LO]
        |=> range_cfg.div_code[0] == 2'h1
    ) else $error("range a bit alone does not give divide-by-2");

    range_b_half_a: assert property (
        !input_range_a[6] && input_range_b[6] && sampling_mode[SAMP_LO + 6]
        |=> range_cfg.div_code[6] == 2'h1
    ) else $error("range b bit alone does not give divide-by-2");

    range_none_a: assert property (
        !input_range_a[7] && !input_range_b[7] |=> range_cfg.div_code[7] == 2'h0
    ) else $error("divide factor applied with both range bits clear");

    range_div4_a: assert property (
        input_range_a[3] && input_range_b[3] && sampling_mode[SAMP_LO + 3]
        |=> range_cfg.div_code[3] == 2'h2
    ) else $error("both range bits do not give divide-by-4");

    range_ignore_a: assert property (
        !sampling_mode[SAMP_LO + 5] |=> range_cfg.div_code[5] == 2'h0
    ) else $error("range bits not ignored for supply-referenced channel");

    supply_ignore_a: assert property (
        !sampling_mode[SAMP_LO] |=> range_cfg.div_code[0] == 2'h0
    ) else $error("first channel range bits not ignored against supply");

    ref_point_a: assert property (
        1'b1 |=> range_cfg.ref_agnd == $past(sampling_mode[SAMP_LO +: NUM_CH])
    ) else $error("reference point does not follow sampling bits 15:8");

    range_reset_a: assert property (
        $rose(rst_n) |-> input_range_a == REG_RESET && input_range_b == REG_RESET
                         && general_config == REG_RESET
    ) else $error("bank not zero after reset");

    reset_all_a: assert property (
        $rose(rst_n) |-> pin_func == REG_RESET && sampling_mode == REG_RESET
                         && shdn_sel_a == REG_RESET && shdn_sel_b == REG_RESET
    ) else $error("select registers not zero after reset");

    reset_outputs_a: assert property (
        $rose(rst_n) |-> range_cfg == '0 && !ref_external && rd_data == REG_RESET
    ) else $error("outputs not at reset values after reset");

    readback_a: assert property (
        is_wr(bus_req, ADDR_GENERAL) ##1 (bus_req.rd && bus_req.addr == ADDR_GENERAL)
        |=> rd_data == $past(bus_req.wdata, 2)
    ) else $error("general register read back differs from write");

    general_store_a: assert property (
        is_wr(bus_req, ADDR_GENERAL) |=> general_config == $past(bus_req.wdata)
    ) else $error("general register lost bits of the written word");

    range_store_a: assert property (
        is_wr(bus_req, ADDR_RANGE_A) |=> input_range_a == $past(bus_req.wdata)
    ) else $error("range register a lost bits of the written word");

    pin_alt_a: assert property (
        pin_func[PIN_ZERO_BIT] |=> !limit_flag_oe_a
    ) else $error("limit flag driven while pin is general-purpose");

    cover_div4_c:   cover property (range_cfg.div_code[0] == 2'h2);
    cover_hiz_c:    cover property (both_shdn && term_mode == MGR_TERM_HIZ ##1
                                    !dac_ctl.large_res_en && !dac_ctl.small_res_en);
    cover_extref_c: cover property ($rose(ref_external));
    cover_flag_c:   cover property (limit_flag_oe_b && limit_flag_out_b);

endmodule

// [include/mgr_pkg.sv]
// shared constants and types for the general and input-range configuration bank
package mgr_pkg;

    // register bus widths, channel count and dac count
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int NUM_CH = 8;
    localparam int NUM_DAC = 4;

    // register offsets within the configuration bank
    localparam logic [7:0] ADDR_PIN_FUNC = 8'h02;
    localparam logic [7:0] ADDR_GENERAL  = 8'h08;
    localparam logic [7:0] ADDR_RANGE_A  = 8'h10;
    localparam logic [7:0] ADDR_RANGE_B  = 8'h11;
    localparam logic [7:0] ADDR_SAMPLING = 8'h12;
    localparam logic [7:0] ADDR_SHDN_A   = 8'h30;
    localparam logic [7:0] ADDR_SHDN_B   = 8'h31;

    // every register in the bank powers up as all zeros
    localparam logic [15:0] REG_RESET = 16'h0000;

    // general_config field positions
    localparam int GEN_REF_BIT    = 8;
    localparam int GEN_POL_B_BIT  = 5;
    localparam int GEN_POL_A_BIT  = 4;
    localparam int GEN_MODE_HI    = 2;
    localparam int GEN_MODE_LO    = 1;

    // pin function register bit positions (0 = alternate function)
    localparam int PIN_ZERO_BIT = 0;
    localparam int PIN_ONE_BIT  = 1;
    localparam int PIN_TWO_BIT  = 2;
    localparam int PIN_FOUR_BIT = 4;

    // sampling mode register: channel n reference select at bit SAMP_LO + n
    localparam int SAMP_LO = 8;

    // shutdown termination mode
    typedef enum logic [1:0] {
        MGR_TERM_BOTH  = 2'h0,
        MGR_TERM_LARGE = 2'h1,
        MGR_TERM_SMALL = 2'h2,
        MGR_TERM_HIZ   = 2'h3
    } mgr_term_t;

    // register access request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } mgr_bus_req_t;

    // dac shutdown control towards the dac output stages
    typedef struct packed {
        logic [NUM_DAC-1:0] off;
        logic               large_res_en;
        logic               small_res_en;
        mgr_term_t          mode;
    } mgr_dac_ctl_t;

    // per-channel range divide code: 0 none, 1 div-by-2, 2 div-by-4
    typedef struct packed {
        logic [NUM_CH-1:0][1:0] div_code;
        logic [NUM_CH-1:0]      ref_agnd;
    } mgr_range_t;

endpackage

// [bench/tb_top.sv]
// self-checking bench for the general and input-range configuration bank
`timescale 1ns/1ps

module tb_top;
    import mgr_pkg::*;

    localparam int OUT_W = 37;

    logic         clk             = 1'b0;
    logic         rst_n           = 1'b0;
    mgr_bus_req_t bus_req         = '0;
    logic         alert_a_raw     = 1'b0;
    logic         alert_b_raw     = 1'b0;
    logic         dac_shutdown_in_a = 1'b0;
    logic         dac_shutdown_in_b = 1'b0;
    logic [15:0]  rd_data;
    logic         ref_external;
    logic         limit_flag_out_a;
    logic         limit_flag_oe_a;
    logic         limit_flag_out_b;
    logic         limit_flag_oe_b;
    mgr_dac_ctl_t dac_ctl;
    mgr_range_t   range_cfg;
    wire  [OUT_W-1:0] outv = {ref_external, limit_flag_out_a, limit_flag_oe_a,
                              limit_flag_out_b, limit_flag_oe_b, dac_ctl, range_cfg};
    int           error_cnt       = 0;
    int           samples_checked = 0;
    integer       seed            = 32'h7a4f;
    logic [7:0]   addrs [7]       = '{ADDR_PIN_FUNC, ADDR_GENERAL, ADDR_RANGE_A, ADDR_RANGE_B,
                                      ADDR_SAMPLING, ADDR_SHDN_A, ADDR_SHDN_B};
    logic [15:0]  shadow [7];

    always #12.5 clk = ~clk;

    mgr_config_bank DUT (
        .clk               (clk),
        .rst_n             (rst_n),
        .bus_req           (bus_req),
        .rd_data           (rd_data),
        .alert_a_raw       (alert_a_raw),
        .alert_b_raw       (alert_b_raw),
        .dac_shutdown_in_a (dac_shutdown_in_a),
        .dac_shutdown_in_b (dac_shutdown_in_b),
        .ref_external      (ref_external),
        .limit_flag_out_a  (limit_flag_out_a),
        .limit_flag_oe_a   (limit_flag_oe_a),
        .limit_flag_out_b  (limit_flag_out_b),
        .limit_flag_oe_b   (limit_flag_oe_b),
        .dac_ctl           (dac_ctl),
        .range_cfg         (range_cfg)
    );

    // expected outputs from the shadow copy of the registers and the present inputs
    function automatic logic [OUT_W-1:0] expect_out();
        logic [15:0]  pf;
        logic [15:0]  gen;
        logic         both;
        mgr_dac_ctl_t d;
        mgr_range_t   r;
        pf = shadow[0];
        gen = shadow[1];
        both = ~pf[PIN_TWO_BIT] & ~pf[PIN_FOUR_BIT];
        d.mode = both ? mgr_term_t'(gen[GEN_MODE_HI:GEN_MODE_LO]) : MGR_TERM_BOTH;
        d.large_res_en = (d.mode == MGR_TERM_BOTH) || (d.mode == MGR_TERM_LARGE);
        d.small_res_en = (d.mode == MGR_TERM_BOTH) || (d.mode == MGR_TERM_SMALL);
        for (int i = 0; i < NUM_DAC; i++) begin
            d.off[i] = (~pf[PIN_TWO_BIT] & dac_shutdown_in_a & shadow[5][i])
                     | (~pf[PIN_FOUR_BIT] & dac_shutdown_in_b & shadow[6][i]);
        end
        for (int n = 0; n < NUM_CH; n++) begin
            r.ref_agnd[n] = shadow[4][SAMP_LO+n];
            r.div_code[n] = shadow[4][SAMP_LO+n]
                          ? {shadow[2][n] & shadow[3][n], shadow[2][n] ^ shadow[3][n]} : 2'h0;
        end
        return {gen[GEN_REF_BIT],
                ~pf[PIN_ZERO_BIT] & ~(alert_a_raw ^ gen[GEN_POL_A_BIT]), ~pf[PIN_ZERO_BIT],
                ~pf[PIN_ONE_BIT] & ~(alert_b_raw ^ gen[GEN_POL_B_BIT]), ~pf[PIN_ONE_BIT],
                d, r};
    endfunction

    task automatic chk_reg(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_out(input string what, input logic [OUT_W-1:0] exp,
                           input logic [OUT_W-1:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    endtask

    task automatic bus_read(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req <= '0;
        #1 d = rd_data;
    endtask

    // writes every register then idles so the derived outputs land one edge later
    task automatic apply_cfg();
        for (int i = 0; i < 7; i++) begin
            bus_write(addrs[i], shadow[i]);
        end
        @(posedge clk);
        bus_req <= '0;
    endtask

    task automatic drive_in(input logic [3:0] v);
        @(posedge clk);
        {alert_a_raw, alert_b_raw, dac_shutdown_in_a, dac_shutdown_in_b} <= v;
    endtask

    task automatic settle_check(input string what);
        @(posedge clk);
        #1 chk_out(what, expect_out(), outv);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #(25 * 20000);
        error_cnt++;
        conclude();
    end

    initial begin
        logic [15:0] v;
        for (int i = 0; i < 7; i++) begin
            shadow[i] = 16'h0;
        end
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            bus_read(addrs[i], v);
            chk_reg("reset value", REG_RESET, v);
        end
        settle_check("outputs after reset");
        $display("test reset_values done");

        // random fill including reserved bits, each read straight after its write
        for (int i = 0; i < 7; i++) begin
            shadow[i] = 16'($random(seed));
            bus_write(addrs[i], shadow[i]);
            bus_read(addrs[i], v);
            chk_reg("readback", shadow[i], v);
        end
        bus_write(8'h09, 16'hffff);
        bus_read(8'h09, v);
        chk_reg("unmapped read", REG_RESET, v);
        bus_read(ADDR_GENERAL, v);
        chk_reg("general after unmapped write", shadow[1], v);
        $display("test readback done");

        // every disable mode, with both pins in shutdown use and with one pin released
        shadow[5] = 16'h0005;
        shadow[6] = 16'h000a;
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 4; m++) begin
                shadow[0] = p ? 16'h0004 : 16'h0000;
                shadow[1] = {13'h0, m[1:0], 1'b0};
                apply_cfg();
                for (int s = 0; s < 4; s++) begin
                    drive_in({2'b00, s[1:0]});
                    settle_check("shutdown mode");
                end
            end
        end
        $display("test shutdown_modes done");

        // both range bits on every channel, half the channels supply-referenced
        shadow = '{16'h0, 16'h0, 16'h00ff, 16'h00ff, 16'haa00, 16'h0, 16'h0};
        apply_cfg();
        settle_check("range corner");
        $display("test range_corner done");

        for (int k = 0; k < 60; k++) begin
            for (int i = 0; i < 7; i++) begin
                shadow[i] = 16'($random(seed));
            end
            apply_cfg();
            settle_check("random config");
            drive_in(4'($random(seed)));
            settle_check("random inputs");
        end
        $display("test random_config done");

        // a reset in mid-run must clear the random setup left behind
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            shadow[i] = 16'h0;
            bus_read(addrs[i], v);
            chk_reg("mid-run reset value", REG_RESET, v);
        end
        settle_check("outputs after mid-run reset");
        $display("test midrun_reset done");
        conclude();
    end

endmodule
